// ---- logic/ist_status_timing.sv ----
/*
 Status flags (address, start, second status register) and master SCL
 timing generator with rise-time compensation.
 Assumes the address matcher, byte engine and checksum engine drive the
 one-cycle event inputs on clk_i; SCL and SDA pins arrive asynchronously.
*/
`timescale 1ns/100ps

// Notes on behaviour
// - Address flag cleared by status reads, disable
// - Slave address match sets address flag
// - Master sets address flag after address ack
// - Not-acknowledged address never sets flag
// - Start flag set, cleared by read/data write
// - Second read clears flag even if late
// - Checksum byte shown in upper status bits
// - Second-match flag from matched own address
// - Host header flag on host address
// - Default address flag with resolution enabled
// - Broadcast call flag when enabled
// - Direction flag from read/write bit
// - Bus busy tracked even when disabled
// - Master state with start, cleared stop/loss
// - Speed bit selects standard or fast
// - Standard high and low equal divider
// - Rise field bounds SCL feedback loop
module ist_status_timing (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// Configuration from control registers
	input wire logic peripheral_enable_i,
	input wire logic checksum_enable_i,
	input wire logic address_resolution_enable_i,
	input wire logic smbus_role_select_i,
	input wire logic broadcast_call_enable_i,
	input wire logic [7:0] checksum_i,
	input wire logic stop_seen_flag_i,
	// Events from the byte engine
	input wire logic slave_match_i,
	input wire logic match_second_i,
	input wire logic match_host_i,
	input wire logic match_default_i,
	input wire logic match_broadcast_i,
	input wire logic master_addr_done_i,
	input wire logic addr_acked_i,
	input wire logic addr_rw_i,
	input wire logic start_made_i,
	input wire logic stop_det_i,
	input wire logic restart_det_i,
	input wire logic arb_lost_i,
	input wire logic scl_run_i,
	// Bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic scl_oe_o,
	// Flags to first status register
	output logic addr_flag_o,
	output logic start_generated_flag_o
);
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic [15:0] clock_control_reg;
	logic [5:0] rise_time_reg;
	logic addr_reg, start_reg, sr1_read_reg;
	logic second_reg, host_reg, default_reg, broadcast_reg;
	logic direction_reg, busy_reg, master_reg;
	logic sda_prev_reg;
	logic [15:0] count_reg;
	logic [5:0] rise_cnt_reg;
	logic scl_low_reg;
	logic [15:0] rdata_next;
	logic [15:0] status_two;
	logic rd_sr1, rd_sr2, wr_dr, clr_frame, scl_s, sda_s;

	typedef enum logic [1:0] {IST_IDLE, IST_LOW, IST_RISE, IST_HIGH} ist_phase_e;
	ist_phase_e phase_reg;

	function automatic logic [15:0] ist_mul(input logic [15:0] a, input logic [15:0] b);
		logic [31:0] p;
		p = 32'(a) * 32'(b);
		return p[15:0];
	endfunction : ist_mul

	assign scl_s = scl_sync_reg[1];
	assign sda_s = sda_sync_reg[1];
	assign rd_sr1 = rd_i && (addr_i == ist_pkg::STATUS_ONE_OFF);
	assign rd_sr2 = rd_i && (addr_i == ist_pkg::STATUS_TWO_OFF);
	assign wr_dr = wr_i && (addr_i == ist_pkg::DATA_REG_OFF);
	assign clr_frame = stop_det_i || restart_det_i || !peripheral_enable_i;

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[0], scl_i};
			sda_sync_reg <= {sda_sync_reg[0], sda_i};
		end
	end

	// Configuration writes
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			clock_control_reg <= ist_pkg::CLOCK_CONTROL_RST;
			rise_time_reg <= ist_pkg::RISE_TIME_RST;
		end
		else if (wr_i)
		begin
			if (addr_i == ist_pkg::CLOCK_CONTROL_OFF)
				clock_control_reg <= {wdata_i[15:14], 2'h0, wdata_i[11:0]};
			if (addr_i == ist_pkg::RISE_TIME_LIMIT_OFF)
				rise_time_reg <= wdata_i[ist_pkg::RISE_MSB:0];
		end
	end

	// Tracks the first-status read that arms both clear sequences
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			sr1_read_reg <= 1'b0;
		else if (rd_sr1)
			sr1_read_reg <= 1'b1;
		else if (rd_sr2 || wr_dr || !peripheral_enable_i)
			sr1_read_reg <= 1'b0;
	end

	// Address flag; set wins over the status-read clear, disable wins over set
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			addr_reg <= 1'b0;
		else if (!peripheral_enable_i)
			addr_reg <= 1'b0;
		else if (slave_match_i && !master_reg)
			addr_reg <= 1'b1;
		else if (master_addr_done_i && addr_acked_i && master_reg)
			addr_reg <= 1'b1;
		else if (rd_sr2 && sr1_read_reg)
			addr_reg <= 1'b0;
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			start_reg <= 1'b0;
		else if (!peripheral_enable_i)
			start_reg <= 1'b0;
		else if (start_made_i)
			start_reg <= 1'b1;
		else if (wr_dr && sr1_read_reg)
			start_reg <= 1'b0;
	end

	// Address-kind flags
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			second_reg <= 1'b0;
			host_reg <= 1'b0;
			default_reg <= 1'b0;
			broadcast_reg <= 1'b0;
		end
		else if (slave_match_i && peripheral_enable_i && !master_reg)
		begin
			second_reg <= match_second_i;
			host_reg <= match_host_i && smbus_role_select_i && address_resolution_enable_i;
			default_reg <= match_default_i && address_resolution_enable_i;
			broadcast_reg <= match_broadcast_i && broadcast_call_enable_i;
		end
		else if (clr_frame)
		begin
			second_reg <= 1'b0;
			host_reg <= 1'b0;
			default_reg <= 1'b0;
			broadcast_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			direction_reg <= 1'b0;
		else if (clr_frame || arb_lost_i)
			direction_reg <= 1'b0;
		else if ((slave_match_i && !master_reg) || (master_addr_done_i && addr_acked_i))
			direction_reg <= master_reg ? !addr_rw_i : addr_rw_i;
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			busy_reg <= 1'b0;
			sda_prev_reg <= 1'b1;
		end
		else
		begin
			sda_prev_reg <= sda_s;
			if (!sda_s || !scl_s)
				busy_reg <= 1'b1;
			else if (sda_s && !sda_prev_reg && scl_s)
				busy_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			master_reg <= 1'b0;
		else if (!peripheral_enable_i || stop_det_i || arb_lost_i)
			master_reg <= 1'b0;
		else if (start_made_i)
			master_reg <= 1'b1;
	end

	always_comb
	begin
		status_two = ist_pkg::STATUS_TWO_RST;
		status_two[15:8] = checksum_enable_i ? checksum_i : 8'h00;
		status_two[ist_pkg::BIT_SECOND] = second_reg;
		status_two[ist_pkg::BIT_HOST] = host_reg;
		status_two[ist_pkg::BIT_DEFAULT] = default_reg;
		status_two[ist_pkg::BIT_BROADCAST] = broadcast_reg;
		status_two[ist_pkg::BIT_DIRECTION] = direction_reg;
		status_two[ist_pkg::BIT_BUSY] = busy_reg;
		status_two[ist_pkg::BIT_MASTER] = master_reg;
	end

	always_comb
	begin
		rdata_next = 16'h0000;
		case (addr_i)
			ist_pkg::STATUS_TWO_OFF: rdata_next = status_two;
			ist_pkg::CLOCK_CONTROL_OFF: rdata_next = clock_control_reg;
			ist_pkg::RISE_TIME_LIMIT_OFF: rdata_next = {10'h000, rise_time_reg};
			ist_pkg::STATUS_ONE_OFF: rdata_next = {14'h0000, addr_reg, start_reg};
			default: rdata_next = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			rdata_o <= 16'h0000;
		else if (rd_i)
			rdata_o <= rdata_next;
		else
			rdata_o <= 16'h0000;
	end

	// Phase lengths in clock cycles
	logic [15:0] div, high_len, low_len;
	assign div = {4'h0, clock_control_reg[ist_pkg::DIV_MSB:0]};
	assign high_len = !clock_control_reg[ist_pkg::SPEED_BIT] ? div :
		(clock_control_reg[ist_pkg::DUTY_BIT] ? ist_mul(div, ist_pkg::DUTY_HIGH_MULT) : div);
	assign low_len = !clock_control_reg[ist_pkg::SPEED_BIT] ? div :
		(clock_control_reg[ist_pkg::DUTY_BIT] ? ist_mul(div, ist_pkg::DUTY_LOW_MULT) :
		ist_mul(div, ist_pkg::FAST_LOW_MULT));

	// SCL generator; divider below minimum is software's fault
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			phase_reg <= IST_IDLE;
			count_reg <= 16'h0000;
			rise_cnt_reg <= 6'h00;
			scl_low_reg <= 1'b0;
		end
		else if (!peripheral_enable_i || !scl_run_i || !master_reg)
		begin
			phase_reg <= IST_IDLE;
			count_reg <= 16'h0000;
			scl_low_reg <= 1'b0;
		end
		else
		begin
			case (phase_reg)
				IST_IDLE:
				begin
					phase_reg <= IST_LOW;
					count_reg <= ist_pkg::ONE_CYCLE;
					scl_low_reg <= 1'b1;
				end
				IST_LOW:
					if (count_reg >= low_len)
					begin
						phase_reg <= IST_RISE;
						rise_cnt_reg <= 6'h01;
						count_reg <= ist_pkg::ONE_CYCLE;
						scl_low_reg <= 1'b0;
					end
					else
						count_reg <= count_reg + ist_pkg::ONE_CYCLE;
				IST_RISE:
				begin
					// wait for SCL high or limit
					count_reg <= count_reg + ist_pkg::ONE_CYCLE;
					rise_cnt_reg <= rise_cnt_reg + 6'h01;
					if (scl_s || rise_cnt_reg >= rise_time_reg)
						phase_reg <= IST_HIGH;
				end
				IST_HIGH:
					if (count_reg >= high_len)
					begin
						phase_reg <= IST_LOW;
						count_reg <= ist_pkg::ONE_CYCLE;
						scl_low_reg <= 1'b1;
					end
					else
						count_reg <= count_reg + ist_pkg::ONE_CYCLE;
				default: phase_reg <= IST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			scl_o <= 1'b0;
			scl_oe_o <= 1'b0;
			addr_flag_o <= 1'b0;
			start_generated_flag_o <= 1'b0;
		end
		else
		begin
			scl_o <= 1'b0;
			scl_oe_o <= scl_low_reg;
			addr_flag_o <= addr_reg;
			start_generated_flag_o <= start_reg;
		end
	end
endmodule : ist_status_timing

// ---- logic/ist_pkg.sv ----
/*
 Package for the two-wire status and SCL timing block: register offsets,
 field positions, reset values and timing constants.
 Assumes a 50 MHz peripheral clock and a plain strobe register port.
*/
package ist_pkg;
	localparam logic [7:0] STATUS_TWO_OFF = 8'h18;
	localparam logic [7:0] CLOCK_CONTROL_OFF = 8'h1c;
	localparam logic [7:0] RISE_TIME_LIMIT_OFF = 8'h20;
	localparam logic [7:0] STATUS_ONE_OFF = 8'h14;
	localparam logic [7:0] DATA_REG_OFF = 8'h10;
	localparam logic [15:0] STATUS_TWO_RST = 16'h0000;
	localparam logic [15:0] CLOCK_CONTROL_RST = 16'h0000;
	localparam logic [5:0] RISE_TIME_RST = 6'h02;
	localparam int SPEED_BIT = 15;
	localparam int DUTY_BIT = 14;
	localparam int DIV_MSB = 11;
	localparam int RISE_MSB = 5;
	localparam int BIT_SECOND = 7;
	localparam int BIT_HOST = 6;
	localparam int BIT_DEFAULT = 5;
	localparam int BIT_BROADCAST = 4;
	localparam int BIT_DIRECTION = 2;
	localparam int BIT_BUSY = 1;
	localparam int BIT_MASTER = 0;
	localparam int BIT_ADDR = 1;
	localparam int BIT_START = 0;
	localparam logic [15:0] FAST_LOW_MULT = 16'h0002;
	localparam logic [15:0] DUTY_HIGH_MULT = 16'h0009;
	localparam logic [15:0] DUTY_LOW_MULT = 16'h0010;
	localparam logic [15:0] ONE_CYCLE = 16'h0001;
endpackage : ist_pkg

// ---- testbench/ist_chk.sv ----
/*
 Checker for the status flags and SCL drive.
 Assumes it is bound to the top module; it sees ports only.
*/
`timescale 1ns/100ps
module ist_chk (
	// Clock, reset, register port
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] addr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	// Config and events
	input wire logic peripheral_enable_i,
	input wire logic checksum_enable_i,
	input wire logic [7:0] checksum_i,
	input wire logic slave_match_i,
	input wire logic master_addr_done_i,
	input wire logic addr_acked_i,
	input wire logic start_made_i,
	// Outputs watched
	input wire logic scl_o,
	input wire logic scl_oe_o,
	input wire logic addr_flag_o,
	input wire logic start_generated_flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence rd_two_s;
		rd_i && addr_i == ist_pkg::STATUS_TWO_OFF && checksum_enable_i;
	endsequence
	sequence set_s;
		peripheral_enable_i && (slave_match_i || master_addr_done_i && addr_acked_i);
	endsequence
	sequence off_s;
		!peripheral_enable_i [*3];
	endsequence
	chk_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
		else $error("read data not zero outside a read");
	chk_pec_shown: assert property (rd_two_s |=> rdata_o[15:8] == $past(checksum_i))
		else $error("checksum byte missing");
	chk_addr_set: assert property (set_s |-> ##2 addr_flag_o)
		else $error("address flag not set");
	chk_addr_nack: assert property (peripheral_enable_i && master_addr_done_i
		&& !addr_acked_i && !slave_match_i && !addr_flag_o |-> ##2 !addr_flag_o)
		else $error("address flag set on nack");
	chk_start_set: assert property (peripheral_enable_i && start_made_i
		|-> ##2 start_generated_flag_o)
		else $error("start flag not set");
	chk_off_clear: assert property (off_s |-> !addr_flag_o && !start_generated_flag_o)
		else $error("flags kept while disabled");
	chk_off_quiet: assert property (off_s |-> !scl_oe_o)
		else $error("SCL pulled while disabled");
	chk_scl_level: assert property (scl_o == 1'b0)
		else $error("SCL driven high");
endmodule : ist_chk

bind ist_status_timing ist_chk ist_chk_inst (.*);

// ---- testbench/ist_bus_peer.sv ----
/*
 Far-side bus model: pull-ups on both lines, optional slow SCL release.
 Assumes the block's pull-low enable is its SCL drive.
*/
`timescale 1ns/100ps
module ist_bus_peer (
	// Clock
	input wire logic clk_i,
	// Controls
	input wire logic scl_pull_i,
	input wire logic slow_i,
	input wire logic sda_low_i,
	// Lines
	output logic scl_o,
	output logic sda_o
);
	logic released_reg;
	always_ff @(posedge clk_i)
	begin
		released_reg <= !scl_pull_i;
	end
	assign scl_o = !scl_pull_i && (released_reg || !slow_i);
	assign sda_o = !sda_low_i;
endmodule : ist_bus_peer

// ---- testbench/test_ist_status_timing.sv ----
/*
 Directed bench: register reads, event pulses, SCL period counts.
 Assumes one 50 MHz clock and the strobe register port.
*/
`timescale 1ns/100ps
module test_ist_status_timing;
	logic clk_i, rst_b_i, wr_i, rd_i, run, slow, sda_low, scl_oe_o, scl_w, sda_w, flag;
	logic sflag, scl_d;
	logic [7:0] addr_i;
	logic [15:0] wdata_i, rdata_o;
	logic [4:0] cf;
	logic [5:0] ev, lv;
	logic [15:0] div [3] = '{16'h0004, 16'h8004, 16'hc001};
	logic [15:0] el [3] = '{16'h0004, 16'h0008, 16'h0010};
	logic [15:0] eh [3] = '{16'h0004, 16'h0004, 16'h0009};
	int mismatches, checks_done, lo, hi;
	ist_status_timing ist_status_timing_inst (
		.clk_i,
		.rst_b_i,
		.addr_i,
		.wdata_i,
		.wr_i,
		.rd_i,
		.rdata_o,
		.peripheral_enable_i(cf[0]),
		.checksum_enable_i(cf[1]),
		.address_resolution_enable_i(cf[2]),
		.smbus_role_select_i(cf[3]),
		.broadcast_call_enable_i(cf[4]),
		.checksum_i(8'h5a),
		.stop_seen_flag_i(1'b0),
		.slave_match_i(ev[0]),
		.match_second_i(lv[0]),
		.match_host_i(lv[1]),
		.match_default_i(lv[2]),
		.match_broadcast_i(lv[3]),
		.master_addr_done_i(ev[1]),
		.addr_acked_i(lv[4]),
		.addr_rw_i(lv[5]),
		.start_made_i(ev[2]),
		.stop_det_i(ev[3]),
		.restart_det_i(ev[4]),
		.arb_lost_i(ev[5]),
		.scl_run_i(run),
		.scl_i(scl_w),
		.sda_i(sda_w),
		.scl_o(scl_d),
		.scl_oe_o,
		.addr_flag_o(flag),
		.start_generated_flag_o(sflag)
	);
	ist_bus_peer ist_bus_peer_inst (
		.clk_i,
		.scl_pull_i(scl_oe_o),
		.slow_i(slow),
		.sda_low_i(sda_low),
		.scl_o(scl_w),
		.sda_o(sda_w)
	);
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic results;
	begin
		$display("Checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask : results
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] got);
	begin
		checks_done++;
		if (got !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, got);
		end
	end
	endtask : chk
	task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] e);
	begin
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		chk(nm, e, rdata_o);
		// Hand back on a rising edge so callers drive there
		@(posedge clk_i);
	end
	endtask : rdc
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
	begin
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clk_i);
		wr_i <= 1'b0;
	end
	endtask : wr
	task automatic pulse(input logic [5:0] v);
	begin
		@(posedge clk_i);
		ev <= v;
		@(posedge clk_i);
		ev <= 6'h00;
	end
	endtask : pulse
	// Bounded wait; a hang ends the run
	task automatic wt(input logic v, output int c);
	begin
		c = 0;
		while (scl_oe_o !== v)
		begin
			@(negedge clk_i);
			c++;
			if (c > 1000)
			begin
				mismatches++;
				results;
			end
		end
	end
	endtask : wt
	initial
	begin
		rst_b_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 16'h0000;
		cf = 5'h00;
		ev = 6'h00;
		lv = 6'h00;
		run = 1'b0;
		slow = 1'b0;
		sda_low = 1'b0;
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rdc("stat2", 8'h18, 16'h0000);
		rdc("clkc", 8'h1c, 16'h0000);
		rdc("rise", 8'h20, 16'h0002);
		rdc("none", 8'h24, 16'h0000);
		sda_low <= 1'b1;
		repeat (4) @(posedge clk_i);
		rdc("busy", 8'h18, 16'h0002);
		sda_low <= 1'b0;
		repeat (4) @(posedge clk_i);
		rdc("busy", 8'h18, 16'h0000);
		cf <= 5'h1f;
		lv <= 6'h2f;
		rdc("stat1", 8'h14, 16'h0000);
		pulse(6'h01);
		// Pin copy trails the internal flag by one cycle
		repeat (2) @(negedge clk_i);
		chk("flag", 16'h0001, {15'h0000, flag});
		rdc("stat2", 8'h18, 16'h5af4);
		rdc("stat1", 8'h14, 16'h0000);
		pulse(6'h10);
		rdc("stat2", 8'h18, 16'h5a00);
		lv <= 6'h10;
		pulse(6'h04);
		repeat (2) @(negedge clk_i);
		chk("sflag", 16'h0001, {15'h0000, sflag});
		rdc("stat2", 8'h18, 16'h5a01);
		rdc("stat1", 8'h14, 16'h0001);
		wr(8'h10, 16'h0000);
		rdc("stat1", 8'h14, 16'h0000);
		pulse(6'h02);
		rdc("stat1", 8'h14, 16'h0002);
		rdc("stat2", 8'h18, 16'h5a05);
		lv <= 6'h00;
		pulse(6'h02);
		rdc("stat1", 8'h14, 16'h0000);
		pulse(6'h20);
		rdc("stat2", 8'h18, 16'h5a00);
		pulse(6'h04);
		cf <= 5'h1e;
		rdc("stat1", 8'h14, 16'h0000);
		for (int i = 0; i < 3; i++)
		begin
			cf <= 5'h1e;
			wr(8'h1c, div[i]);
			wr(8'h20, 16'h0003);
			rdc("clkc", 8'h1c, div[i]);
			cf <= 5'h1f;
			slow <= i[0];
			pulse(6'h04);
			run <= 1'b1;
			wt(1'b0, lo);
			wt(1'b1, lo);
			wt(1'b0, lo);
			wt(1'b1, hi);
			chk("low", el[i], lo[15:0]);
			chk("high", eh[i], hi[15:0]);
			chk("scl", 16'h0000, {15'h0000, scl_d});
			@(posedge clk_i);
			run <= 1'b0;
		end
		results;
	end
endmodule : test_ist_status_timing
